// ==== verilog/tefi_top.sv ====
// Functional notes
// - a read that is part of an alias read-modify-write returns 1 in every event flag bit.
// - alias writes and normal writes with a byte select off are read-modify-write; full-width normal writes never mask.
// - an alias write reads the register, replaces one bit and writes it all back, so other flags stay.
// - a read through the alias region returns the true unmasked value.
// - each of three counters sets a zero flag at count 0x0000, interrupt while flag and enable are set.
// - each of three counters sets a peak flag at its cycle setting, gated by its own enable.
// - each of six compare channels sets a match flag when its counter equals its compare value.
// - each of four capture channels sets an edge flag on a valid edge, gated by its enable.
// - shutdown and wave timer flags have no enable and always drive their interrupt.
// - the shutdown input sets the shutdown flag which raises the shutdown interrupt.
// - three wave timer completion flags each drive their own interrupt.
// - writing 0 clears a flag, writing 1 does nothing, reads show whether the event occurred.
// - each enabled interrupt is flag AND enable, and the enable is freely read and written.
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
module tefi_top
  import tefi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [47:0] free_running_counter_i,
  input wire logic [TEFI_NCAP-1:0] capture_edge_i,
  input wire logic shutdown_i,
  input wire logic [TEFI_NWAVE-1:0] wave_done_i,
  output logic [TEFI_NCNT-1:0] zero_irq_o,
  output logic [TEFI_NCNT-1:0] peak_irq_o,
  output logic [TEFI_NCMP-1:0] cmp_irq_o,
  output logic [TEFI_NCAP-1:0] cap_irq_o,
  output logic shutdown_irq_o,
  output logic [TEFI_NWAVE-1:0] wave_irq_o,
  output logic irq_o
);
  tefi_evt_s flag_ff;
  tefi_evt_s nxt_flag;
  tefi_evt_s evt;
  tefi_evt_s clr;
  tefi_evt_s en_ff;
  tefi_evt_s nxt_en;
  logic [15:0] cycle_ff [TEFI_NCNT];
  logic [15:0] cmpval_ff [TEFI_NCMP];
  logic [1:0] cmpsel_ff [TEFI_NCMP];
  logic [31:0] mask_ff;
  logic [TEFI_NCAP-1:0] cap_s1_ff;
  logic [TEFI_NCAP-1:0] cap_s2_ff;
  logic [TEFI_NCAP-1:0] cap_s3_ff;
  logic shut_s1_ff;
  logic shut_s2_ff;
  logic [TEFI_NWAVE-1:0] wave_s1_ff;
  logic [TEFI_NWAVE-1:0] wave_s2_ff;
  logic req;
  logic alias_acc;
  logic [7:0] off;
  logic [4:0] bitsel;
  logic [31:0] rd_true;
  logic [31:0] rd_flagmask;
  logic [31:0] wr_val;
  logic [31:0] wr_strobe;
  logic [15:0] cnt [TEFI_NCNT];

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign alias_acc = wb_adr_i[TEFI_ALIAS_BIT];
  // alias: adr[7:5] picks the word, adr[4:0] the bit in it
  assign off = alias_acc ? {3'b000, wb_adr_i[7:5], 2'b00} : {wb_adr_i[7:2], 2'b00};
  assign bitsel = {wb_adr_i[4:0]};
  assign wr_strobe = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // input synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_s1_ff <= '0;
      cap_s2_ff <= '0;
      cap_s3_ff <= '0;
      shut_s1_ff <= 1'b0;
      shut_s2_ff <= 1'b0;
      wave_s1_ff <= '0;
      wave_s2_ff <= '0;
    end else begin
      cap_s1_ff <= capture_edge_i;
      cap_s2_ff <= cap_s1_ff;
      cap_s3_ff <= cap_s2_ff;
      shut_s1_ff <= shutdown_i;
      shut_s2_ff <= shut_s1_ff;
      wave_s1_ff <= wave_done_i;
      wave_s2_ff <= wave_s1_ff;
    end
  end

  // event detection
  always_comb begin
    evt = '0;
    for (int c = 0; c < TEFI_NCNT; c++) begin
      cnt[c] = free_running_counter_i[c*16 +: 16];
      evt.zero[c] = (cnt[c] == TEFI_ZERO_COUNT);
      evt.peak[c] = (cnt[c] == cycle_ff[c]);
    end
    for (int k = 0; k < TEFI_NCMP; k++) begin
      evt.cmp[k] = (free_running_counter_i[cmpsel_ff[k]*16 +: 16] == cmpval_ff[k]);
    end
    evt.cap = cap_s2_ff & ~cap_s3_ff;
    evt.shut = shut_s2_ff;
    evt.wave = wave_s2_ff;
  end

  // true register images
  function automatic logic [31:0] image(input logic [7:0] a, input tefi_evt_s f, input tefi_evt_s e, input logic m);
    logic [31:0] v;
    v = '0;
    case (a)
      TEFI_OFF_CNT_STAT: begin
        for (int c = 0; c < TEFI_NCNT; c++) begin
          v[c*TEFI_CNT_STRIDE] = f.zero[c] | m;
          v[c*TEFI_CNT_STRIDE+1] = e.zero[c];
          v[c*TEFI_CNT_STRIDE+2] = f.peak[c] | m;
          v[c*TEFI_CNT_STRIDE+3] = e.peak[c];
        end
      end
      TEFI_OFF_CMP_STAT: begin
        for (int k = 0; k < TEFI_NCMP; k++) begin
          v[2*k] = f.cmp[k] | m;
          v[2*k+1] = e.cmp[k];
        end
      end
      TEFI_OFF_CAP_STAT: begin
        for (int k = 0; k < TEFI_NCAP; k++) begin
          v[2*k] = f.cap[k] | m;
          v[2*k+1] = e.cap[k];
        end
      end
      TEFI_OFF_WAVE_IRQ: v[TEFI_NWAVE:0] = {f.wave, f.shut} | {(TEFI_NWAVE+1){m}};
      default: v = '0;
    endcase
    return v;
  endfunction

  always_comb begin
    rd_true = image(off, flag_ff, en_ff, 1'b0);
    rd_flagmask = image(off, flag_ff, en_ff, 1'b1);
    if (alias_acc) begin
      wr_val = rd_flagmask;
      wr_val[bitsel] = wb_dat_i[0];
    end else begin
      wr_val = (wb_dat_i & wr_strobe) | ~wr_strobe;
      if (!wb_sel_i[0] || !wb_sel_i[1] || !wb_sel_i[2] || !wb_sel_i[3]) begin
        wr_val = (wb_dat_i & wr_strobe) | (rd_true & ~wr_strobe);
        wr_val = wr_val | (rd_flagmask & ~rd_true & ~wr_strobe);
      end
    end
  end

  // clear and enable decode
  always_comb begin
    clr = '0;
    nxt_en = en_ff;
    if (req && wb_we_i) begin
      case (off)
        TEFI_OFF_CNT_STAT: begin
          for (int c = 0; c < TEFI_NCNT; c++) begin
            clr.zero[c] = !wr_val[c*TEFI_CNT_STRIDE];
            nxt_en.zero[c] = wr_val[c*TEFI_CNT_STRIDE+1];
            clr.peak[c] = !wr_val[c*TEFI_CNT_STRIDE+2];
            nxt_en.peak[c] = wr_val[c*TEFI_CNT_STRIDE+3];
          end
        end
        TEFI_OFF_CMP_STAT: begin
          for (int k = 0; k < TEFI_NCMP; k++) begin
            clr.cmp[k] = !wr_val[2*k];
            nxt_en.cmp[k] = wr_val[2*k+1];
          end
        end
        TEFI_OFF_CAP_STAT: begin
          for (int k = 0; k < TEFI_NCAP; k++) begin
            clr.cap[k] = !wr_val[2*k];
            nxt_en.cap[k] = wr_val[2*k+1];
          end
        end
        TEFI_OFF_WAVE_IRQ: begin
          clr.shut = !wr_val[0];
          clr.wave = ~wr_val[TEFI_NWAVE:1];
        end
        default: clr = '0;
      endcase
    end
    nxt_en.shut = 1'b1;
    nxt_en.wave = '1;
    nxt_flag = (flag_ff & ~clr) | evt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= '0;
      en_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
      en_ff <= nxt_en;
    end
  end

  // setting registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < TEFI_NCNT; c++) cycle_ff[c] <= TEFI_CYCLE_RST;
      for (int k = 0; k < TEFI_NCMP; k++) begin
        cmpval_ff[k] <= TEFI_CYCLE_RST;
        cmpsel_ff[k] <= 2'd0;
      end
      mask_ff <= TEFI_MASK_RST;
    end else if (req && wb_we_i && !alias_acc) begin
      for (int c = 0; c < TEFI_NCNT; c++) begin
        if (off == TEFI_OFF_CYCLE0 + 8'(4*c)) cycle_ff[c] <= wr_val[15:0];
      end
      for (int k = 0; k < TEFI_NCMP; k++) begin
        if (off == TEFI_OFF_CMP_BASE + 8'(4*k)) cmpval_ff[k] <= wr_val[15:0];
      end
      if (off == TEFI_OFF_CMP_SEL) begin
        for (int k = 0; k < TEFI_NCMP; k++) cmpsel_ff[k] <= (wr_val[2*k +: 2] == 2'd3) ? 2'd0 : wr_val[2*k +: 2];
      end
      if (off == TEFI_OFF_IRQ_MASK) mask_ff <= wr_val;
    end
  end

  // bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_true;
        for (int c = 0; c < TEFI_NCNT; c++) begin
          if (off == TEFI_OFF_CYCLE0 + 8'(4*c)) wb_dat_o <= {16'h0000, cycle_ff[c]};
        end
        for (int k = 0; k < TEFI_NCMP; k++) begin
          if (off == TEFI_OFF_CMP_BASE + 8'(4*k)) wb_dat_o <= {16'h0000, cmpval_ff[k]};
        end
        if (off == TEFI_OFF_IRQ_MASK) wb_dat_o <= mask_ff;
        if (off == TEFI_OFF_CMP_SEL) begin
          for (int k = 0; k < TEFI_NCMP; k++) wb_dat_o[2*k +: 2] <= cmpsel_ff[k];
        end
      end
    end
  end

  // interrupt lines
  tefi_evt_s line;
  assign line = flag_ff & en_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_irq_o <= '0;
      peak_irq_o <= '0;
      cmp_irq_o <= '0;
      cap_irq_o <= '0;
      shutdown_irq_o <= 1'b0;
      wave_irq_o <= '0;
      irq_o <= 1'b0;
    end else begin
      zero_irq_o <= line.zero;
      peak_irq_o <= line.peak;
      cmp_irq_o <= line.cmp;
      cap_irq_o <= line.cap;
      shutdown_irq_o <= flag_ff.shut;
      wave_irq_o <= flag_ff.wave;
      // a mask bit of 1 blocks that line
      irq_o <= |(line & ~mask_ff[$bits(tefi_evt_s)-1:0]);
    end
  end

  AST_CLEAR_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && !alias_acc && off == TEFI_OFF_CAP_STAT && wb_sel_i[0] && !wb_dat_i[0] && !evt.cap[0]
    |=> !flag_ff.cap[0]) else $error("write 0 did not clear");
  AST_WRITE_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_ff.cap[1] && req && wb_we_i && !alias_acc && off == TEFI_OFF_CAP_STAT && wb_dat_i[2]
    |=> flag_ff.cap[1]) else $error("write 1 cleared flag");
  AST_ALIAS_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_ff.cap[1] && req && wb_we_i && alias_acc && off == TEFI_OFF_CAP_STAT && bitsel == 5'd0
    |=> flag_ff.cap[1]) else $error("alias write cleared neighbour");
  AST_ALIAS_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && alias_acc && off == TEFI_OFF_CAP_STAT && bitsel == 5'd0 && !wb_dat_i[0] && !evt.cap[0]
    |=> !flag_ff.cap[0]) else $error("alias write missed target");
  AST_ALIAS_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && alias_acc && off == TEFI_OFF_CAP_STAT && !flag_ff.cap[0] && !evt.cap[0]
    |=> !wb_dat_o[0]) else $error("alias read masked");
  AST_EVENT_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
    evt.shut |=> flag_ff.shut) else $error("event lost");
  AST_ZERO_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt[0] == 16'h0000 |=> flag_ff.zero[0]) else $error("zero not flagged");
  AST_PEAK_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_ff.peak[2] && en_ff.peak[2] |=> peak_irq_o[2]) else $error("peak irq missing");
  AST_SHUT_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    shut_s2_ff |=> ##1 shutdown_irq_o) else $error("shutdown irq missing");
  AST_CMP_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    evt.cmp[5] |=> flag_ff.cmp[5]) else $error("compare not flagged");
  AST_CAP_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_ff.cap[2] |=> !cap_irq_o[2]) else $error("capture irq ungated");
  AST_WAVE_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_ff.wave[2] |=> wave_irq_o[2]) else $error("wave irq missing");
  COV_ALIAS_WR: cover property (@(posedge clk_i) req && wb_we_i && alias_acc);
  COV_SHUT: cover property (@(posedge clk_i) shutdown_irq_o);
  COV_RACE: cover property (@(posedge clk_i) evt.zero[0] && clr.zero[0]);
endmodule

// ==== verilog/tefi_pkg.sv ====
package tefi_pkg;
  // register byte offsets (normal region); alias address is 0x100 + (offset/4)*32 + bit number
  localparam logic [7:0] TEFI_OFF_CNT_STAT = 8'h00;
  localparam logic [7:0] TEFI_OFF_CMP_STAT = 8'h04;
  localparam logic [7:0] TEFI_OFF_CAP_STAT = 8'h08;
  localparam logic [7:0] TEFI_OFF_WAVE_IRQ = 8'h0C;
  localparam logic [7:0] TEFI_OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] TEFI_OFF_CYCLE0 = 8'h14;
  localparam logic [7:0] TEFI_OFF_CYCLE1 = 8'h18;
  localparam logic [7:0] TEFI_OFF_CYCLE2 = 8'h1C;
  localparam logic [7:0] TEFI_OFF_CMP_BASE = 8'h20;
  localparam logic [7:0] TEFI_OFF_CMP_SEL = 8'h38;
  // address bit selecting the alias region
  localparam int TEFI_ALIAS_BIT = 8;
  // layout of counter status: per channel c: flag zero 4c, zero en 4c+1, peak 4c+2, peak en 4c+3
  localparam int TEFI_CNT_STRIDE = 4;
  // compare status: flag bit 2k, enable bit 2k+1 for channel k
  // capture status: flag bit 2k, enable bit 2k+1 for channel k
  // wave irq: bit0 shutdown, bits 3:1 wave timers
  localparam int TEFI_NCNT = 3;
  localparam int TEFI_NCMP = 6;
  localparam int TEFI_NCAP = 4;
  localparam int TEFI_NWAVE = 3;
  localparam logic [15:0] TEFI_ZERO_COUNT = 16'h0000;
  localparam logic [15:0] TEFI_CYCLE_RST = 16'hFFFF;
  localparam logic [31:0] TEFI_MASK_RST = 32'h0000_0000;
  typedef struct packed {
    logic [TEFI_NCNT-1:0] zero;
    logic [TEFI_NCNT-1:0] peak;
    logic [TEFI_NCMP-1:0] cmp;
    logic [TEFI_NCAP-1:0] cap;
    logic shut;
    logic [TEFI_NWAVE-1:0] wave;
  } tefi_evt_s;
endpackage

// ==== bench/tefi_irq_sink.sv ====
module tefi_irq_sink (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic irq_i,
  output logic [7:0] hits_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_ff;
  // counts handler entries, one per rising request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
      hits_o <= 8'h00;
    end else begin
      irq_ff <= irq_i;
      if (irq_i && !irq_ff) begin
        hits_o <= hits_o + 8'h01;
      end
    end
  end
endmodule

// ==== bench/test_timer_event_flag_interrupts.sv ====
module test_timer_event_flag_interrupts
  import tefi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [8:0] A_CNT = {1'b0, TEFI_OFF_CNT_STAT};
  localparam logic [8:0] A_CMP = {1'b0, TEFI_OFF_CMP_STAT};
  localparam logic [8:0] A_CAP = {1'b0, TEFI_OFF_CAP_STAT};
  localparam logic [8:0] A_WAV = {1'b0, TEFI_OFF_WAVE_IRQ};
  localparam logic [8:0] A_MSK = {1'b0, TEFI_OFF_IRQ_MASK};
  localparam logic [47:0] BASE = 48'h0001_0001_0001;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [8:0] adr = 9'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [47:0] frc = BASE;
  logic [3:0] cap = 4'h0;
  logic shut = 1'b0;
  logic [2:0] wave = 3'h0;
  logic [2:0] zero_irq;
  logic [2:0] peak_irq;
  logic [5:0] cmp_irq;
  logic [3:0] cap_irq;
  logic shut_irq;
  logic [2:0] wave_irq;
  logic irq;
  logic [7:0] hits;
  int miscompares = 0;
  int tests_run = 0;
  always #2.5 clk_i = ~clk_i;
  tefi_top i_tefi_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .free_running_counter_i(frc), .capture_edge_i(cap), .shutdown_i(shut), .wave_done_i(wave),
    .zero_irq_o(zero_irq), .peak_irq_o(peak_irq), .cmp_irq_o(cmp_irq), .cap_irq_o(cap_irq),
    .shutdown_irq_o(shut_irq), .wave_irq_o(wave_irq), .irq_o(irq));
  tefi_irq_sink i_tefi_irq_sink (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .hits_o(hits));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string what, input logic [8:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(what, q, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    tick(2);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) rdc("reset status", 9'(i * 4), 32'h0000_0000);
    rdc("reset cycle", {1'b0, TEFI_OFF_CYCLE0}, 32'h0000_FFFF);
    frc <= 48'h0001_0001_0000;
    tick(1);
    frc <= BASE;
    tick(3);
    rdc("zero flag", A_CNT, 32'h0000_0001);
    chk("zero irq off", {29'h0, zero_irq}, 32'h0);
    wr(A_CNT, 32'h0000_0557);
    tick(2);
    chk("zero irq on", {29'h0, zero_irq}, 32'h1);
    chk("irq line", {31'h0, irq}, 32'h1);
    chk("handler entries", {24'h0, hits}, 32'h1);
    tick(8);
    rdc("zero sticky", A_CNT, 32'h0000_0003);
    wr(A_MSK, 32'h0002_0000);
    tick(2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(A_MSK, 32'h0000_0000);
    wr(A_CNT, 32'h0000_0556);
    tick(2);
    rdc("zero cleared", A_CNT, 32'h0000_0002);
    chk("zero irq clr", {29'h0, zero_irq}, 32'h0);
    // zero event stands only at the edge that takes the clear
    frc <= 48'h0001_0001_0000;
    fork
      wr(A_CNT, 32'h0000_0556);
      begin
        tick(1);
        frc <= BASE;
      end
    join
    rdc("clear vs event", A_CNT, 32'h0000_0003);
    wr(A_CNT, 32'h0000_0000);
    wr({1'b0, TEFI_OFF_CYCLE2}, 32'h0000_0005);
    frc <= 48'h0005_0001_0001;
    tick(1);
    frc <= BASE;
    tick(3);
    rdc("peak flag", A_CNT, 32'h0000_0400);
    wr(A_CNT, 32'h0000_0D55);
    tick(2);
    chk("peak irq", {29'h0, peak_irq}, 32'h4);
    wr(A_CNT, 32'h0000_0000);
    wr({1'b0, TEFI_OFF_CMP_SEL}, 32'h0000_0800);
    wr({1'b0, TEFI_OFF_CMP_BASE}, 32'h0000_0007);
    wr({1'b0, TEFI_OFF_CMP_BASE + 8'h14}, 32'h0000_0009);
    frc <= 48'h0009_0001_0007;
    tick(1);
    frc <= BASE;
    tick(3);
    rdc("match flags", A_CMP, 32'h0000_0401);
    wr(A_CMP, 32'h0000_0FFF);
    tick(2);
    chk("match irq", {26'h0, cmp_irq}, 32'h21);
    wr(A_CMP, 32'h0000_0000);
    cap <= 4'b0011;
    tick(4);
    cap <= 4'b0000;
    tick(2);
    rdc("edge flags", A_CAP, 32'h0000_0005);
    wr(A_CAP, 32'h0000_00FF);
    tick(2);
    chk("edge irq", {28'h0, cap_irq}, 32'h3);
    wr(9'h140, 32'h0000_0000);
    rdc("alias rmw", A_CAP, 32'h0000_00AE);
    rdc("alias read", 9'h140, 32'h0000_00AE);
    wr(A_CAP, 32'h0000_00AA);
    rdc("normal write", A_CAP, 32'h0000_00AA);
    shut <= 1'b1;
    tick(1);
    shut <= 1'b0;
    wave <= 3'b101;
    tick(1);
    wave <= 3'b000;
    tick(4);
    chk("shutdown irq", {31'h0, shut_irq}, 32'h1);
    chk("wave irq", {29'h0, wave_irq}, 32'h5);
    rdc("wave flags", A_WAV, 32'h0000_000B);
    wr(A_WAV, 32'hFFFF_FFFD);
    rdc("wave one clr", A_WAV, 32'h0000_0009);
    wr(A_WAV, 32'h0000_0000);
    tick(2);
    chk("wave irq clr", {28'h0, wave_irq, shut_irq}, 32'h0);
    report_and_stop();
  end
endmodule
